// >>> hdl/mcs_control_status.sv
// Lower control status register of a four-line serial multiplexer, bits 0 to 15 with enables and flags.
// Assumes the host bus logic gives one-cycle read and write strobes on this clock.
`timescale 1ns/1ps
`default_nettype none
module mcs_control_status #(
   parameter int unsigned LINES = mcs_pkg::NUM_LINES,
   parameter int unsigned ALARM_AT = mcs_pkg::ALARM_COUNT
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic clock_enable,
   input wire logic bus_init_pulse,
   input wire logic csr_write,
   input wire logic [1:0] csr_byte_enable,
   input wire logic [15:0] csr_write_data,
   output logic [15:0] csr_read_data,
   input wire logic rx_fifo_output_read,
   input wire logic rx_fifo_entry,
   input wire logic rx_fifo_not_empty,
   input wire logic [LINES-1:0] tx_buffer_free,
   input wire logic [LINES-1:0] tx_line_enable_reg,
   input wire logic [LINES-1:0] uart_tx_serial,
   input wire logic [LINES-1:0] line_rx_serial,
   output logic [LINES-1:0] uart_rx_serial,
   output logic scan_run_enable,
   output logic silo_flush,
   output logic device_reinit_active,
   output logic rx_irq_request,
   output logic tx_irq_request
);
   import mcs_pkg::*;
   initial begin
      if (LINES != 4) $error("mcs_control_status: LINES must be 4");
      if (ALARM_AT < 1 || ALARM_AT > 31) $error("mcs_control_status: ALARM_AT out of range");
   end
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [15:0] csr_rw;
   logic [2:0] reinit_count;
   logic [4:0] alarm_count;
   logic fifo_alarm_flag;
   logic tx_line_ready;
   logic [1:0] tx_service_line;
   logic [1:0] scan_line;
   logic [LINES-1:0] rx_sync_a;
   logic [LINES-1:0] rx_sync_b;
   logic rx_char_available;
   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   logic clear_all;
   logic loopback_test;
   logic fifo_alarm_enable;
   logic rx_irq_enable;
   logic tx_irq_enable;
   logic [15:0] byte_mask;
   logic [15:0] next_csr_rw;
   logic start_reinit;
   logic stop_ready;
   logic scan_hit;
   logic next_alarm_flag;
   logic [4:0] next_alarm_count;
   // Either initialise source clears the whole register.
   assign clear_all = bus_init_pulse || device_reinit_active;
   assign loopback_test = csr_rw[BIT_LOOPBACK];
   assign scan_run_enable = csr_rw[BIT_SCAN];
   assign rx_irq_enable = csr_rw[BIT_RX_IE];
   assign fifo_alarm_enable = csr_rw[BIT_ALARM_EN];
   assign tx_irq_enable = csr_rw[BIT_TX_IE];
   // The initialise output must not reach the transmit enable upper byte or modem status.
   assign device_reinit_active = reinit_count != 3'h0;
   assign silo_flush = !scan_run_enable || clear_all;
   // Only lanes that are enabled change; read-only bits are masked away.
   assign byte_mask = {{8{csr_byte_enable[1]}}, {8{csr_byte_enable[0]}}} & CSR_WRITE_MASK;
   assign next_csr_rw = (csr_rw & ~byte_mask) | (csr_write_data & byte_mask);
   assign start_reinit = csr_write && csr_byte_enable[0] && csr_write_data[BIT_REINIT];
   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Unused bits are tied to zero so reads never show stale write data.
   assign csr_read_data = {tx_line_ready, tx_irq_enable, fifo_alarm_flag, fifo_alarm_enable,
      2'b00, tx_service_line, rx_char_available, csr_rw[6:5], device_reinit_active,
      loopback_test, 3'b000};
   // ----------------------------------------------------------------
   // Loopback path
   // ----------------------------------------------------------------
   // The pin input is synchronised; the internal transmitter output needs none.
   assign uart_rx_serial = loopback_test ? uart_tx_serial : rx_sync_b;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_sync_a <= '1;
         rx_sync_b <= '1;
      end else if (clock_enable) begin
         rx_sync_a <= line_rx_serial;
         rx_sync_b <= rx_sync_a;
      end
   end
   // ----------------------------------------------------------------
   // Control register and re-initialise timer
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         csr_rw <= CSR_RESET;
         reinit_count <= 3'h0;
      end else if (clock_enable) begin
         if (clear_all) csr_rw <= CSR_RESET;
         else if (csr_write) csr_rw <= next_csr_rw;
         if (bus_init_pulse) reinit_count <= 3'h0;
         else if (start_reinit && !device_reinit_active) reinit_count <= 3'(REINIT_CYCLES);
         else if (device_reinit_active) reinit_count <= reinit_count - 3'h1;
      end
   end
   // ----------------------------------------------------------------
   // Receive side: available flag and silo alarm
   // ----------------------------------------------------------------
   mcs_rx_stage u_rx_stage (
      .clock(clock),
      .resetn(resetn),
      .clock_enable(clock_enable),
      .flush(silo_flush),
      .queued(rx_fifo_not_empty),
      .taken(rx_fifo_output_read),
      .available(rx_char_available)
   );
   // An entry on the same cycle as a read still counts toward the next alarm.
   assign next_alarm_count = (!fifo_alarm_enable || silo_flush || rx_fifo_output_read) ?
      5'(rx_fifo_entry && fifo_alarm_enable && !silo_flush) :
      (rx_fifo_entry && alarm_count < 5'(ALARM_AT)) ? alarm_count + 5'h01 : alarm_count;
   assign next_alarm_flag = fifo_alarm_enable && !silo_flush &&
      (next_alarm_count == 5'(ALARM_AT) || (fifo_alarm_flag && !rx_fifo_output_read));
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         alarm_count <= 5'h00;
         fifo_alarm_flag <= 1'b0;
      end else if (clock_enable) begin
         alarm_count <= next_alarm_count;
         fifo_alarm_flag <= next_alarm_flag;
      end
   end
   // Alarm enable masks the per-character source, leaving polled mode when both clear.
   assign rx_irq_request = rx_irq_enable &&
      ((rx_char_available && !fifo_alarm_enable) || fifo_alarm_flag);
   // ----------------------------------------------------------------
   // Transmit scanner
   // ----------------------------------------------------------------
   assign scan_hit = scan_run_enable && tx_buffer_free[scan_line] && tx_line_enable_reg[scan_line];
   // Ready drops if the serviced line is disabled or its buffer is loaded.
   assign stop_ready = !tx_line_enable_reg[tx_service_line] || !tx_buffer_free[tx_service_line];
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         scan_line <= 2'h0;
         tx_line_ready <= 1'b0;
         tx_service_line <= 2'h0;
      end else if (clock_enable) begin
         if (!scan_run_enable || clear_all) begin
            scan_line <= 2'h0;
            tx_line_ready <= 1'b0;
            tx_service_line <= 2'h0;
         end else if (tx_line_ready) begin
            if (stop_ready) tx_line_ready <= 1'b0;
         end else if (scan_hit) begin
            tx_line_ready <= 1'b1;
            tx_service_line <= scan_line;
         end else begin
            scan_line <= scan_line + 2'h1;
         end
      end
   end
   assign tx_irq_request = tx_irq_enable && tx_line_ready;
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_init_clears_reg: assert property (@(posedge clock) disable iff (!resetn)
      clock_enable && bus_init_pulse |=> csr_rw == CSR_RESET)
      else $error("bus initialise did not clear register");
   a_reinit_self_clear: assert property (@(posedge clock) disable iff (!resetn)
      clock_enable && start_reinit && !device_reinit_active && !bus_init_pulse
      |=> device_reinit_active ##0 csr_read_data[BIT_REINIT] ##4 !device_reinit_active)
      else $error("re-initialise did not self-clear");
   a_byte_write_lane: assert property (@(posedge clock) disable iff (!resetn)
      clock_enable && csr_write && !clear_all && csr_byte_enable == 2'b01
      |=> csr_rw[15:8] == $past(csr_rw[15:8]))
      else $error("byte write changed upper byte");
   a_unused_zero: assert property (@(posedge clock) disable iff (!resetn)
      csr_read_data[2:0] == 3'b000 && csr_read_data[11:10] == 2'b00)
      else $error("unused bits not zero");
   a_ready_needs_scan: assert property (@(posedge clock) disable iff (!resetn)
      !scan_run_enable |=> !tx_line_ready && tx_service_line == 2'h0)
      else $error("transmit ready or line set without scan enable");
   a_ready_enabled: assert property (@(posedge clock) disable iff (!resetn)
      !tx_line_ready && !(tx_line_enable_reg[scan_line] && tx_buffer_free[scan_line])
      |=> !tx_line_ready)
      else $error("transmit ready on disabled line");
   a_tx_irq_gate: assert property (@(posedge clock) disable iff (!resetn)
      tx_irq_request |-> tx_irq_enable && tx_line_ready)
      else $error("transmit interrupt without cause");
   a_rx_irq_cause: assert property (@(posedge clock) disable iff (!resetn)
      rx_irq_request |-> rx_irq_enable && (fifo_alarm_flag || !fifo_alarm_enable))
      else $error("receive interrupt without cause");
   a_loopback_path: assert property (@(posedge clock) disable iff (!resetn)
      loopback_test |-> uart_rx_serial == uart_tx_serial)
      else $error("loopback path broken");
   c_reinit: cover property (@(posedge clock) disable iff (!resetn) $fell(device_reinit_active));
   c_tx_ready: cover property (@(posedge clock) disable iff (!resetn) $rose(tx_line_ready));
   c_alarm: cover property (@(posedge clock) disable iff (!resetn) $rose(fifo_alarm_flag));
   c_rx_irq: cover property (@(posedge clock) disable iff (!resetn) $rose(rx_irq_request));
endmodule : mcs_control_status
`default_nettype wire

// >>> hdl/mcs_pkg.sv
// Package for the lower control status register block of a four-line serial multiplexer.
// Assumes a single 250 MHz clock domain shared by the bus interface and the block.
package mcs_pkg;
   // ----------------------------------------------------------------
   // Bit positions of the control status register
   // ----------------------------------------------------------------
   localparam int unsigned BIT_LOOPBACK = 3;
   localparam int unsigned BIT_REINIT = 4;
   localparam int unsigned BIT_SCAN = 5;
   localparam int unsigned BIT_RX_IE = 6;
   localparam int unsigned BIT_RX_AVAIL = 7;
   localparam int unsigned BIT_LINE_LO = 8;
   localparam int unsigned BIT_LINE_HI = 9;
   localparam int unsigned BIT_ALARM_EN = 12;
   localparam int unsigned BIT_ALARM = 13;
   localparam int unsigned BIT_TX_IE = 14;
   localparam int unsigned BIT_TX_READY = 15;
   localparam logic [15:0] CSR_RESET = 16'h0000;
   // Bits software may write; the rest are read-only or unused.
   localparam logic [15:0] CSR_WRITE_MASK = 16'h5078;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_MHZ = 250;
   localparam int unsigned SHIFT_DELAY_NS = 1000;
   // Longest time: rounded down, at least one cycle.
   localparam int unsigned SHIFT_DELAY_CYCLES = (SHIFT_DELAY_NS * CLOCK_MHZ) / 1000;
   localparam int unsigned REINIT_CYCLES = 4;
   localparam int unsigned ALARM_COUNT = 16;
   localparam int unsigned NUM_LINES = 4;
endpackage : mcs_pkg

// >>> hdl/mcs_rx_stage.sv
// Receive output stage: models the shift-down delay before a queued character appears.
// Assumes character arrival flags come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mcs_rx_stage #(
   parameter int unsigned DELAY = mcs_pkg::SHIFT_DELAY_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic clock_enable,
   input wire logic flush,
   input wire logic queued,
   input wire logic taken,
   output logic available
);
   import mcs_pkg::*;
   initial begin
      if (DELAY < 1 || DELAY > 1023) $error("mcs_rx_stage: DELAY out of range");
   end
   logic [9:0] wait_count;
   logic [9:0] next_wait_count;
   logic next_available;
   // ----------------------------------------------------------------
   // Shift-down timer
   // ----------------------------------------------------------------
   // A read restarts the wait so the flag cannot reappear before the shift ends.
   // A flush leaves no wait, so the first new character shows at once.
   assign next_wait_count = flush ? 10'h000 : taken ? 10'(DELAY) :
                            (wait_count != 10'h000) ? wait_count - 10'h001 : 10'h000;
   assign next_available = !flush && !taken && queued && (wait_count <= 10'h001);
   // State updates only while enabled.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wait_count <= 10'h000;
         available <= 1'b0;
      end else if (clock_enable) begin
         wait_count <= next_wait_count;
         available <= next_available;
      end
   end
   a_flag_cleared_read: assert property (@(posedge clock) disable iff (!resetn)
      clock_enable && taken |=> !available)
      else $error("available stayed set after read");
endmodule : mcs_rx_stage
`default_nettype wire

// >>> testbench/mcs_silo_model.sv
// Behavioural receive silo standing beside the control status block.
// Assumes the bench pulses push for one cycle per arriving character.
`timescale 1ns/1ps
`default_nettype none
module mcs_silo_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic push,
   input wire logic pop,
   input wire logic flush,
   output logic entry,
   output logic not_empty
);
   // ----------------------------------------------------------------
   // Character count
   // ----------------------------------------------------------------
   int count;
   // A flushed silo takes nothing in, so no entry is reported then.
   assign entry = push & ~flush;
   assign not_empty = (count != 0);
   // Flush empties the silo whatever else happens in that cycle.
   always @(posedge clock or negedge resetn) begin
      if (!resetn || flush) begin
         count <= 0;
      end else begin
         count <= count + (entry ? 1 : 0) - ((pop && count != 0) ? 1 : 0);
      end
   end
endmodule : mcs_silo_model
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the lower control status register block.
// Assumes one 250 MHz clock; the silo model stands on the receive side.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mcs_pkg::*;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic bus_init_pulse = 1'b0;
   logic clock_enable = 1'b1;
   logic csr_write = 1'b0;
   logic [1:0] csr_byte_enable = 2'b00;
   logic [15:0] csr_write_data = 16'h0000;
   logic rx_read = 1'b0;
   logic push = 1'b0;
   logic [3:0] tx_free = 4'h0;
   logic [3:0] tx_en = 4'h0;
   logic [3:0] tx_ser = 4'h0;
   logic [3:0] rx_pin = 4'hf;
   wire logic [15:0] rd;
   wire logic [3:0] rx_ser;
   wire logic scan, flush, reinit, rx_irq, tx_irq, entry, not_empty;
   int failures = 0;
   int checks_done = 0;
   mcs_control_status DUT (.clock(clock), .resetn(resetn), .clock_enable(clock_enable),
      .bus_init_pulse(bus_init_pulse), .csr_write(csr_write),
      .csr_byte_enable(csr_byte_enable), .csr_write_data(csr_write_data),
      .csr_read_data(rd), .rx_fifo_output_read(rx_read), .rx_fifo_entry(entry),
      .rx_fifo_not_empty(not_empty), .tx_buffer_free(tx_free),
      .tx_line_enable_reg(tx_en), .uart_tx_serial(tx_ser), .line_rx_serial(rx_pin),
      .uart_rx_serial(rx_ser), .scan_run_enable(scan), .silo_flush(flush),
      .device_reinit_active(reinit), .rx_irq_request(rx_irq), .tx_irq_request(tx_irq));
   mcs_silo_model silo (.clock(clock), .resetn(resetn), .push(push), .pop(rx_read),
      .flush(flush), .entry(entry), .not_empty(not_empty));
   // Clock of 4 ns period.
   initial begin
      forever #2 clock = ~clock;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // A write is one strobe cycle and one idle edge, so calls in a row never re-raise at once.
   task automatic wr(input logic [1:0] be, input logic [15:0] d);
      csr_write = 1'b1;
      csr_byte_enable = be;
      csr_write_data = d;
      tick(1);
      csr_write = 1'b0;
      tick(1);
   endtask : wr
   task automatic pulse_pop();
      rx_read = 1'b1;
      tick(1);
      rx_read = 1'b0;
   endtask : pulse_pop
   // Push stays high for n edges, one entry per edge, then one idle edge.
   task automatic pulse_push(input int n);
      push = 1'b1;
      tick(n);
      push = 1'b0;
      tick(1);
   endtask : pulse_push
   // Polls one register bit under a bound, then compares it.
   task automatic wait_bit(input int b, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && rd[b] !== v; i++) tick(1);
      chk(rd[b], v);
   endtask : wait_bit
   task automatic report_and_stop();
      $display("checks_done=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   // Watchdog: the whole sequence needs under 400 cycles.
   initial begin
      #100000;
      failures++;
      report_and_stop();
   end
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      tick(3);
      resetn = 1'b1;
      chk(rd, CSR_RESET);
      chk(flush, 1'b1);
      // The high-lane write carries low data that must not start an initialise.
      wr(2'b10, 16'hffff);
      chk(rd, 16'hff00 & CSR_WRITE_MASK);
      chk(reinit, 1'b0);
      wr(2'b01, 16'h00ef);
      chk(rd, 16'hffef & CSR_WRITE_MASK);
      wr(2'b01, 16'h0000);
      chk(rd, 16'h5000);
      // Loopback routes transmitter outputs, otherwise the synchronised pins.
      wr(2'b11, 16'h0008);
      tx_ser = 4'ha;
      rx_pin = 4'h5;
      tick(1);
      chk(rx_ser, 4'ha);
      wr(2'b11, 16'h0000);
      tick(3);
      chk(rx_ser, 4'h5);
      // Receive flag, interrupt and the shift-down gap after a read.
      wr(2'b11, 16'h0060);
      chk(scan, 1'b1);
      chk(flush, 1'b0);
      pulse_push(2);
      wait_bit(BIT_RX_AVAIL, 1'b1, 400);
      chk(rx_irq, 1'b1);
      pulse_pop();
      chk(rd[BIT_RX_AVAIL], 1'b0);
      tick(SHIFT_DELAY_CYCLES / 2);
      chk(rd[BIT_RX_AVAIL], 1'b0);
      wait_bit(BIT_RX_AVAIL, 1'b1, SHIFT_DELAY_CYCLES + 20);
      // Alarm mode keeps the receive interrupt quiet until sixteen entries.
      wr(2'b11, 16'h1060);
      chk(rx_irq, 1'b0);
      pulse_pop();
      pulse_push(ALARM_COUNT - 1);
      chk(rd[BIT_ALARM], 1'b0);
      pulse_push(1);
      chk(rd[BIT_ALARM], 1'b1);
      chk(rx_irq, 1'b1);
      pulse_pop();
      chk(rd[BIT_ALARM], 1'b0);
      // Transmit ready on line two, then the line enable drops.
      tx_en = 4'b0100;
      tx_free = 4'b0100;
      wr(2'b11, 16'h4020);
      wait_bit(BIT_TX_READY, 1'b1, 20);
      chk(rd[9:8], 2'd2);
      chk(tx_irq, 1'b1);
      tx_en = 4'b0000;
      wait_bit(BIT_TX_READY, 1'b0, 4);
      tx_en = 4'b0100;
      wr(2'b11, 16'h0020);
      wait_bit(BIT_TX_READY, 1'b1, 20);
      chk(tx_irq, 1'b0);
      // Scan off zeroes the line field and flushes the silo.
      pulse_push(1);
      wr(2'b11, 16'h0000);
      tick(1);
      chk(rd, 16'h0000);
      chk(flush, 1'b1);
      chk(not_empty, 1'b0);
      // Internal initialise reads back set, then clears itself.
      wr(2'b11, 16'h0068);
      wr(2'b01, 16'h0010);
      chk(rd, 16'h0010);
      chk(reinit, 1'b1);
      tick(REINIT_CYCLES + 1);
      chk(rd, 16'h0000);
      chk(reinit, 1'b0);
      // Bus initialise clears every bit.
      wr(2'b11, 16'h5068);
      bus_init_pulse = 1'b1;
      tick(1);
      bus_init_pulse = 1'b0;
      tick(1);
      chk(rd, 16'h0000);
      // With the clock enable low a write must leave the register frozen.
      clock_enable = 1'b0;
      wr(2'b11, 16'h0068);
      chk(rd, 16'h0000);
      clock_enable = 1'b1;
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
